// ==== alu_array_pkg.sv ====
package alu_array_pkg;

    // microinstruction formats that steer the working-register address decode
    typedef enum logic [2:0] {
        KIND_DECODE   = 3'b000,
        KIND_MEM_REQ  = 3'b001,
        KIND_MOVE     = 3'b010,
        KIND_BASIC    = 3'b011,
        KIND_EXTENDED = 3'b100,
        KIND_MISC     = 3'b101
    } uinst_kind_t;

    // operand pairs presented to the R and S inputs
    typedef enum logic [2:0] {
        SRC_A_Q = 3'b000,
        SRC_A_B = 3'b001,
        SRC_Z_Q = 3'b010,
        SRC_Z_B = 3'b011,
        SRC_Z_A = 3'b100,
        SRC_D_A = 3'b101,
        SRC_D_Q = 3'b110,
        SRC_D_Z = 3'b111
    } src_ctl_t;

    typedef enum logic [2:0] {
        FN_ADD       = 3'b000,
        FN_S_MINUS_R = 3'b001,
        FN_R_MINUS_S = 3'b010,
        FN_OR        = 3'b011,
        FN_AND       = 3'b100,
        FN_MASK      = 3'b101,
        FN_XOR       = 3'b110,
        FN_XNOR      = 3'b111
    } alu_fn_t;

    typedef enum logic [2:0] {
        DST_LOAD_Q     = 3'b000,
        DST_NOP        = 3'b001,
        DST_WRITE_B_A  = 3'b010,
        DST_WRITE_B_F  = 3'b011,
        DST_RSHF_RAM_Q = 3'b100,
        DST_RSHF_RAM   = 3'b101,
        DST_LSHF_RAM_Q = 3'b110,
        DST_LSHF_RAM   = 3'b111
    } dest_ctl_t;

    // source of the bit that enters a register at the end opposite the shift
    typedef enum logic [1:0] {
        LINK_ZERO   = 2'b00,
        LINK_ROTATE = 2'b01,
        LINK_CROSS  = 2'b10,
        LINK_EXT    = 2'b11
    } shift_link_t;

    typedef struct packed {
        uinst_kind_t kind;
        logic [10:7] control_store_word;
        logic [1:0] move_destination_select;
        src_ctl_t src;
        alu_fn_t fn;
        dest_ctl_t dest;
        logic carry_in;
        shift_link_t link;
        logic link_in;
    } micro_word_t;

    typedef struct packed {
        logic ovf;
        logic carry;
        logic sign;
        logic zero;
    } alu_flags_t;

    localparam int BUS_W = 32;
    localparam int ADDR_W = 4;
    localparam int RAM_ADDR_W = 4;

    localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_Q = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_RESULT = 4'hc;
    localparam int CTRL_HOLD_BIT = 0;
    localparam logic CTRL_HOLD_RESET = 1'b0;

    localparam logic [1:0] MDS_WIDE = 2'h2;
    localparam logic [RAM_ADDR_W-1:0] MEM_REQ_B_ADDR = 4'h5;
endpackage

// ==== sliced_alu_array.sv ====
// The placing of the registers and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - per-slice zero detects combined into zero flag
// - sign flag is result bit 31
// - ram read during cycle, written at its end
// - q register loads on rising clock edge
// - eight 4-bit slices form 32-bit datapath
// - sixteen words, only eight reachable by decode
// - three arithmetic and five logic functions
// - zero operand pairs with D, Q, A, B
// - ram stores result unshifted, left or right
// - q shifts one bit left or right
// - shift links rotate or cross ram/q
// - output is alu result or a-port data
// - two reads; equal addresses give same word
// - ram write only at b address
// - upper address bits of both ports zero
// - decode b address is bit9 then zeros
// - memory request b address fixed at five
// - move/basic b field addresses both ports
// - move with select two forces b bit2
// - extended: a from 10:9, b from 8:7
// - misc uses bit7 on both ports
// - function codes 0..7 map to operations
// - destination code 1 holds ram and q; output and flags still load
module sliced_alu_array
    import alu_array_pkg::*;
#(
    parameter int SLICES = 8,
    parameter int SLICE_W = 4,
    parameter int RAM_WORDS = 16
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire micro_word_t uinst,
    input wire logic [SLICES*SLICE_W-1:0] d_bus,
    output logic [SLICES*SLICE_W-1:0] y_out,
    output alu_flags_t flags_out,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [BUS_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [BUS_W-1:0] avs_readdata,
    output logic avs_waitrequest
);
    localparam int DATA_W = SLICES * SLICE_W;

    if (DATA_W != BUS_W || SLICE_W < 2) begin : g_bad_width
        $error("sliced_alu_array: slices must form a 32-bit word");
    end
    if (RAM_WORDS != (1 << RAM_ADDR_W)) begin : g_bad_depth
        $error("sliced_alu_array: ram depth must match 4-bit addresses");
    end

    function automatic logic pick_link(input shift_link_t mode, input logic own, input logic other,
                                       input logic ext);
        logic bit_v;
        bit_v = 1'b0;
        case (mode)
            LINK_ZERO: bit_v = 1'b0;
            LINK_ROTATE: bit_v = own;
            LINK_CROSS: bit_v = other;
            LINK_EXT: bit_v = ext;
            default: bit_v = 1'b0;
        endcase
        return bit_v;
    endfunction

    // ---------------- working-register address decode
    wire logic cs10 = uinst.control_store_word[10];
    wire logic cs9 = uinst.control_store_word[9];
    wire logic cs8 = uinst.control_store_word[8];
    wire logic cs7 = uinst.control_store_word[7];
    wire logic move_wide = (uinst.kind == KIND_MOVE) && (uinst.move_destination_select == MDS_WIDE);
    logic [1:0] a_low;
    logic [2:0] b_low;
    wire logic [RAM_ADDR_W-1:0] a_port_address = {2'h0, a_low};
    wire logic [RAM_ADDR_W-1:0] b_port_address = {1'h0, b_low};

    always_comb begin
        a_low = 2'h0;
        b_low = 3'h0;
        case (uinst.kind)
            KIND_DECODE: b_low = {cs9, 2'h0};
            KIND_MEM_REQ: b_low = MEM_REQ_B_ADDR[2:0];
            KIND_MOVE: begin
                a_low = {cs8, cs7};
                b_low = {move_wide, cs8, cs7};
            end
            KIND_BASIC: begin
                a_low = {cs8, cs7};
                b_low = {1'b0, cs8, cs7};
            end
            KIND_EXTENDED: begin
                a_low = {cs10, cs9};
                b_low = {1'b0, cs8, cs7};
            end
            KIND_MISC: begin
                // bit 8 is left out on purpose; microcode keeps it clear
                a_low = {1'b0, cs7};
                b_low = {2'h0, cs7};
            end
            default: begin
                a_low = 2'h0;
                b_low = 3'h0;
            end
        endcase
    end

    // ---------------- storage
    // words above seven exist but the decode never reaches them
    logic [DATA_W-1:0] wr_ram [RAM_WORDS];
    logic [DATA_W-1:0] q_q, q_d;
    logic [DATA_W-1:0] y_q;
    alu_flags_t flags_q;
    logic hold_q;

    // both ports read asynchronously for the whole cycle
    wire logic [DATA_W-1:0] a_data = wr_ram[a_port_address];
    wire logic [DATA_W-1:0] b_data = wr_ram[b_port_address];

    // ---------------- source select
    logic [DATA_W-1:0] r_op, s_op;

    always_comb begin
        r_op = '0;
        s_op = '0;
        case (uinst.src)
            SRC_A_Q: begin r_op = a_data; s_op = q_q; end
            SRC_A_B: begin r_op = a_data; s_op = b_data; end
            SRC_Z_Q: begin r_op = '0; s_op = q_q; end
            SRC_Z_B: begin r_op = '0; s_op = b_data; end
            SRC_Z_A: begin r_op = '0; s_op = a_data; end
            SRC_D_A: begin r_op = d_bus; s_op = a_data; end
            SRC_D_Q: begin r_op = d_bus; s_op = q_q; end
            SRC_D_Z: begin r_op = d_bus; s_op = '0; end
            default: begin r_op = '0; s_op = '0; end
        endcase
    end

    // ---------------- arithmetic with slice look-ahead
    wire logic fn_arith = (uinst.fn == FN_ADD) || (uinst.fn == FN_S_MINUS_R) || (uinst.fn == FN_R_MINUS_S);
    wire logic [DATA_W-1:0] r_alu = (uinst.fn == FN_S_MINUS_R) ? ~r_op : r_op;
    wire logic [DATA_W-1:0] s_alu = (uinst.fn == FN_R_MINUS_S) ? ~s_op : s_op;
    logic [SLICES:0] carry_chain;
    logic [SLICES-1:0] slice_prop, slice_gen, slice_zero;
    logic [DATA_W-1:0] sum;
    logic [DATA_W-1:0] alu_f;

    assign carry_chain[0] = uinst.carry_in;

    for (genvar i = 0; i < SLICES; i++) begin : g_slice
        wire logic [SLICE_W-1:0] r_n = r_alu[i*SLICE_W +: SLICE_W];
        wire logic [SLICE_W-1:0] s_n = s_alu[i*SLICE_W +: SLICE_W];
        wire logic [SLICE_W:0] raw = {1'b0, r_n} + {1'b0, s_n};
        assign slice_gen[i] = raw[SLICE_W];
        assign slice_prop[i] = &(r_n ^ s_n);
        // carry into each slice comes from the look-ahead terms, not the slice below's adder
        assign carry_chain[i+1] = slice_gen[i] | (slice_prop[i] & carry_chain[i]);
        assign sum[i*SLICE_W +: SLICE_W] = raw[SLICE_W-1:0] + {{(SLICE_W-1){1'b0}}, carry_chain[i]};
        assign slice_zero[i] = ~|alu_f[i*SLICE_W +: SLICE_W];
    end

    always_comb begin
        alu_f = '0;
        case (uinst.fn)
            FN_ADD, FN_S_MINUS_R, FN_R_MINUS_S: alu_f = sum;
            FN_OR: alu_f = r_op | s_op;
            FN_AND: alu_f = r_op & s_op;
            FN_MASK: alu_f = ~r_op & s_op;
            FN_XOR: alu_f = r_op ^ s_op;
            FN_XNOR: alu_f = ~(r_op ^ s_op);
            default: alu_f = '0;
        endcase
    end

    // carry and overflow are only meaningful for arithmetic; logic functions report neither
    wire logic top_carry_in = sum[DATA_W-1] ^ r_alu[DATA_W-1] ^ s_alu[DATA_W-1];
    alu_flags_t flags_d;
    assign flags_d.zero = &slice_zero;
    assign flags_d.sign = alu_f[DATA_W-1];
    assign flags_d.carry = fn_arith & carry_chain[SLICES];
    assign flags_d.ovf = fn_arith & (top_carry_in ^ carry_chain[SLICES]);

    // ---------------- destination and shift links
    wire dest_ctl_t dest = uinst.dest;
    wire logic shift_right = (dest == DST_RSHF_RAM_Q) || (dest == DST_RSHF_RAM);
    wire logic shift_left = (dest == DST_LSHF_RAM_Q) || (dest == DST_LSHF_RAM);
    wire logic ram_we = !hold_q && (dest != DST_LOAD_Q) && (dest != DST_NOP);
    wire logic q_we = !hold_q && ((dest == DST_LOAD_Q) || (dest == DST_RSHF_RAM_Q) || (dest == DST_LSHF_RAM_Q));
    wire logic ram_msb_in = pick_link(uinst.link, alu_f[0], q_q[0], uinst.link_in);
    wire logic ram_lsb_in = pick_link(uinst.link, alu_f[DATA_W-1], q_q[DATA_W-1], uinst.link_in);
    wire logic q_msb_in = pick_link(uinst.link, q_q[0], alu_f[0], uinst.link_in);
    wire logic q_lsb_in = pick_link(uinst.link, q_q[DATA_W-1], alu_f[DATA_W-1], uinst.link_in);
    wire logic [DATA_W-1:0] ram_in = shift_right ? {ram_msb_in, alu_f[DATA_W-1:1]} :
                                     shift_left ? {alu_f[DATA_W-2:0], ram_lsb_in} : alu_f;

    always_comb begin
        q_d = q_q;
        case (dest)
            DST_LOAD_Q: q_d = alu_f;
            DST_RSHF_RAM_Q: q_d = {q_msb_in, q_q[DATA_W-1:1]};
            DST_LSHF_RAM_Q: q_d = {q_q[DATA_W-2:0], q_lsb_in};
            default: q_d = q_q;
        endcase
    end

    wire logic [DATA_W-1:0] y_d = (dest == DST_WRITE_B_A) ? a_data : alu_f;

    // one clock is one microcycle: writes land on the edge that closes it
    always_ff @(posedge clk_sys) begin
        if (ram_we) begin
            wr_ram[b_port_address] <= ram_in;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            q_q <= '0;
        end else if (q_we) begin
            q_q <= q_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            y_q <= '0;
            flags_q <= '0;
        end else begin
            y_q <= y_d;
            flags_q <= flags_d;
        end
    end

    assign y_out = y_q;
    assign flags_out = flags_q;

    // ---------------- avalon slave: one wait state on every access
    logic wait_q;
    logic [BUS_W-1:0] rdata_q;
    wire logic access = avs_read || avs_write;
    wire logic [BUS_W-1:0] rd_mux = (avs_address == OFS_CTRL) ? {{(BUS_W-1){1'b0}}, hold_q} :
                                    (avs_address == OFS_STATUS) ? {{(BUS_W-4){1'b0}}, flags_q} :
                                    (avs_address == OFS_Q) ? q_q :
                                    (avs_address == OFS_RESULT) ? y_q : '0;
    wire logic ctrl_wr = avs_write && !wait_q && (avs_address == OFS_CTRL) && avs_byteenable[0];

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            wait_q <= 1'b1;
            rdata_q <= '0;
            hold_q <= CTRL_HOLD_RESET;
        end else begin
            wait_q <= !(access && wait_q);
            if (avs_read && wait_q) begin
                rdata_q <= rd_mux;
            end
            if (ctrl_wr) begin
                hold_q <= avs_writedata[CTRL_HOLD_BIT];
            end
        end
    end

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;

    // ---------------- checks
    a_zero_flag: assert property (@(posedge clk_sys) disable iff (!resetn)
        1'b1 |=> flags_out.zero == ($past(alu_f) == '0))
        else $error("zero flag does not match result");
    a_sign_bit: assert property (@(posedge clk_sys) disable iff (!resetn)
        dest != DST_WRITE_B_A |=> flags_out.sign == y_out[DATA_W-1])
        else $error("sign flag is not result msb");
    a_q_load: assert property (@(posedge clk_sys) disable iff (!resetn)
        (dest == DST_LOAD_Q && !hold_q) |=> q_q == $past(alu_f))
        else $error("q did not load result");
    a_q_right_shift: assert property (@(posedge clk_sys) disable iff (!resetn)
        (dest == DST_RSHF_RAM_Q && !hold_q) |=> q_q[DATA_W-2:0] == $past(q_q[DATA_W-1:1]))
        else $error("q right shift wrong");
    a_ram_b_write: assert property (@(posedge clk_sys) disable iff (!resetn)
        ram_we |=> wr_ram[$past(b_port_address)] == $past(ram_in))
        else $error("ram word at b address not written");
    a_nop_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
        dest == DST_NOP |=> $stable(q_q))
        else $error("nop changed q");
    a_addr_upper: assert property (@(posedge clk_sys) disable iff (!resetn)
        a_port_address[3:2] == 2'h0 && b_port_address[3] == 1'b0)
        else $error("undriven address bits not zero");
    a_memreq_addr: assert property (@(posedge clk_sys) disable iff (!resetn)
        uinst.kind == KIND_MEM_REQ |-> b_port_address == MEM_REQ_B_ADDR)
        else $error("memory request b address not five");
    a_move_wide: assert property (@(posedge clk_sys) disable iff (!resetn)
        move_wide |-> b_port_address[2] && a_port_address[1:0] == b_port_address[1:0])
        else $error("move select two did not widen b address");
    a_same_word: assert property (@(posedge clk_sys) disable iff (!resetn)
        a_port_address == b_port_address |-> a_data == b_data)
        else $error("equal addresses read different words");
    a_out_select: assert property (@(posedge clk_sys) disable iff (!resetn)
        dest == DST_WRITE_B_A |=> y_out == $past(a_data))
        else $error("output did not select a-port data");
    a_add_func: assert property (@(posedge clk_sys) disable iff (!resetn)
        uinst.fn == FN_ADD |-> alu_f == DATA_W'(r_op + s_op + {{(DATA_W-1){1'b0}}, uinst.carry_in}))
        else $error("add result wrong");
    a_bus_answer: assert property (@(posedge clk_sys) disable iff (!resetn)
        (access && wait_q) |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one cycle after request");
endmodule
`default_nettype wire

// ==== uword_source.sv ====
`timescale 1ns/100ps
`default_nettype none
module uword_source
    import alu_array_pkg::*;
(
    input wire micro_word_t req,
    input wire logic [31:0] req_d,
    output var micro_word_t uinst,
    output logic [31:0] d_bus
);
    // misc words always leave bit 8 clear, so both ports see only register 0 or 1
    always_comb begin
        uinst = req;
        if (req.kind == KIND_MISC) begin
            uinst.control_store_word[8] = 1'b0;
        end
    end
    // no format can name registers 8 and up, so the control store never touches them
    assign d_bus = req_d;
endmodule
`default_nettype wire

// ==== sliced_alu_array_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module sliced_alu_array_tb
    import alu_array_pkg::*;
;
    typedef struct {int stamp; logic [31:0] y; logic [3:0] f;} note_t;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    micro_word_t req, uinst;
    alu_flags_t flags_out;
    logic [31:0] req_d, d_bus, y_out, rd, v, qv, avs_writedata, avs_readdata;
    logic [3:0] avs_address, avs_byteenable;
    logic avs_read, avs_write, avs_waitrequest, cin_v, li_v, hold_v;
    logic [31:0] wr [16];
    shift_link_t link_v;
    note_t notes [$];
    note_t n;
    int cnt = 0;
    int num_errors = 0;
    int cmp_count = 0;
    always #2 clk_sys = ~clk_sys;
    uword_source u_src (.req(req), .req_d(req_d), .uinst(uinst), .d_bus(d_bus));
    sliced_alu_array u_dut (.clk_sys(clk_sys), .resetn(resetn), .uinst(uinst), .d_bus(d_bus), .y_out(y_out),
        .flags_out(flags_out), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    task automatic check(logic [31:0] got, logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            num_errors++;
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    function automatic logic [35:0] alu_ref(alu_fn_t fn, logic [31:0] r, logic [31:0] s, logic ci);
        logic [31:0] a, b, f;
        logic [32:0] t;
        logic c, o;
        a = (fn == FN_S_MINUS_R) ? ~r : r;
        b = (fn == FN_R_MINUS_S) ? ~s : s;
        t = {1'b0, a} + {1'b0, b} + {32'h0, ci};
        c = 1'b0;
        o = 1'b0;
        case (fn)
            FN_OR: f = r | s;
            FN_AND: f = r & s;
            FN_MASK: f = ~r & s;
            FN_XOR: f = r ^ s;
            FN_XNOR: f = ~(r ^ s);
            default: begin
                f = t[31:0];
                c = t[32];
                o = a[31] ^ b[31] ^ t[31] ^ t[32];
            end
        endcase
        return {o, c, f[31], f == 32'h0, f};
    endfunction
    // returns {ram word, q word} after a one-bit shift with the chosen link fill
    function automatic logic [63:0] shf(logic left, shift_link_t lk, logic [31:0] f, logic [31:0] q, logic li);
        logic fi, qi;
        case (lk)
            LINK_ZERO: {fi, qi} = 2'b00;
            LINK_ROTATE: {fi, qi} = left ? {f[31], q[31]} : {f[0], q[0]};
            LINK_CROSS: {fi, qi} = left ? {q[31], f[31]} : {q[0], f[0]};
            default: {fi, qi} = {li, li};
        endcase
        return left ? {f[30:0], fi, q[30:0], qi} : {fi, f[31:1], qi, q[31:1]};
    endfunction
    function automatic logic [3:0] b_adr(micro_word_t w);
        case (w.kind)
            KIND_DECODE: return {1'b0, w.control_store_word[9], 2'h0};
            KIND_MEM_REQ: return 4'h5;
            KIND_MOVE: return {1'b0, w.move_destination_select == 2'h2, w.control_store_word[8:7]};
            KIND_MISC: return {3'h0, w.control_store_word[7]};
            default: return {2'h0, w.control_store_word[8:7]};
        endcase
    endfunction
    function automatic logic [3:0] a_adr(micro_word_t w);
        case (w.kind)
            KIND_EXTENDED: return {2'h0, w.control_store_word[10:9]};
            KIND_MISC: return {3'h0, w.control_store_word[7]};
            KIND_DECODE, KIND_MEM_REQ: return 4'h0;
            default: return {2'h0, w.control_store_word[8:7]};
        endcase
    endfunction
    function automatic micro_word_t mk(uinst_kind_t k, logic [3:0] cs, logic [1:0] m, src_ctl_t s, alu_fn_t f,
        dest_ctl_t d);
        return '{k, cs, m, s, f, d, cin_v, link_v, li_v};
    endfunction
    // issues one microword and notes the result expected one edge later
    task automatic step(micro_word_t w, logic [31:0] d);
        logic [31:0] a, b, r, s;
        logic [35:0] o;
        logic [63:0] sh;
        note_t m;
        a = wr[a_adr(w)];
        b = wr[b_adr(w)];
        case (w.src)
            SRC_A_Q: {r, s} = {a, qv};
            SRC_A_B: {r, s} = {a, b};
            SRC_Z_Q: {r, s} = {32'h0, qv};
            SRC_Z_B: {r, s} = {32'h0, b};
            SRC_Z_A: {r, s} = {32'h0, a};
            SRC_D_A: {r, s} = {d, a};
            SRC_D_Q: {r, s} = {d, qv};
            default: {r, s} = {d, 32'h0};
        endcase
        o = alu_ref(w.fn, r, s, w.carry_in);
        sh = shf(w.dest[1], w.link, o[31:0], qv, w.link_in);
        m.y = (w.dest == DST_WRITE_B_A) ? a : o[31:0];
        m.f = o[35:32];
        @(posedge clk_sys);
        req <= w;
        req_d <= d;
        m.stamp = cnt;
        notes.push_back(m);
        if (!hold_v) begin
            case (w.dest)
                DST_LOAD_Q: qv = o[31:0];
                DST_WRITE_B_A, DST_WRITE_B_F: wr[b_adr(w)] = o[31:0];
                DST_RSHF_RAM, DST_LSHF_RAM: wr[b_adr(w)] = sh[63:32];
                DST_RSHF_RAM_Q, DST_LSHF_RAM_Q: {wr[b_adr(w)], qv} = sh;
                default: ;
            endcase
        end
    endtask
    task automatic bus(logic w, logic [3:0] adr, logic [31:0] wd, logic [3:0] be);
        int k;
        @(posedge clk_sys);
        avs_address <= adr;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= wd;
        avs_byteenable <= be;
        for (k = 0; k < 20; k++) begin
            @(posedge clk_sys);
            if (avs_waitrequest === 1'b0) break;
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (k == 20) begin
            num_errors++;
            complete_run();
        end
    endtask
    task automatic rdchk(logic [3:0] adr, logic [31:0] exp);
        bus(1'b0, adr, 32'h0, 4'hf);
        check(rd, exp);
    endtask
    // results land one edge after issue, so a note is judged at the second falling edge
    always @(negedge clk_sys) begin
        while (notes.size() > 0 && notes[0].stamp < cnt) begin
            n = notes.pop_front();
            check(y_out, n.y);
            check({28'h0, flags_out}, {28'h0, n.f});
        end
        cnt <= cnt + 1;
    end
    initial begin
        {cin_v, li_v, hold_v, qv, req_d, avs_read, avs_write, avs_address, avs_writedata} = '0;
        avs_byteenable = 4'hf;
        link_v = LINK_ZERO;
        req = mk(KIND_BASIC, 4'h0, 2'h0, SRC_D_Z, FN_ADD, DST_NOP);
        void'($urandom(32'h4f06fefe));
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        rdchk(OFS_CTRL, 32'h0);
        rdchk(OFS_STATUS, 32'h1);
        rdchk(OFS_Q, 32'h0);
        rdchk(OFS_RESULT, 32'h0);
        $display("test reset finished");
        for (int i = 0; i < 4; i++) step(mk(KIND_BASIC, 4'(i), 2'h0, SRC_D_Z, FN_ADD, DST_WRITE_B_F), $urandom);
        // the wide move also reaches words 6 and 7; unknowns there would spread unevenly through the slices
        for (int i = 0; i < 4; i++) step(mk(KIND_MOVE, 4'(i), 2'h2, SRC_D_Z, FN_ADD, DST_WRITE_B_F), $urandom);
        step(mk(KIND_MOVE, 4'h1, 2'h2, SRC_Z_B, FN_OR, DST_NOP), 32'h0);
        step(mk(KIND_BASIC, 4'h3, 2'h0, SRC_D_Z, FN_ADD, DST_LOAD_Q), $urandom);
        step(mk(KIND_DECODE, 4'h4, 2'h0, SRC_D_Z, FN_ADD, DST_WRITE_B_F), $urandom);
        step(mk(KIND_MOVE, 4'h0, 2'h2, SRC_Z_B, FN_OR, DST_NOP), 32'h0);
        step(mk(KIND_DECODE, 4'h0, 2'h0, SRC_D_Z, FN_ADD, DST_WRITE_B_F), $urandom);
        step(mk(KIND_MEM_REQ, 4'hf, 2'h0, SRC_Z_A, FN_ADD, DST_WRITE_B_F), $urandom);
        step(mk(KIND_MOVE, 4'h1, 2'h2, SRC_Z_B, FN_OR, DST_NOP), 32'h0);
        step(mk(KIND_EXTENDED, 4'h9, 2'h0, SRC_D_Z, FN_ADD, DST_WRITE_B_A), $urandom);
        step(mk(KIND_BASIC, 4'h1, 2'h0, SRC_A_B, FN_XOR, DST_NOP), $urandom);
        step(mk(KIND_MISC, 4'h1, 2'h0, SRC_A_B, FN_ADD, DST_WRITE_B_F), 32'h0);
        $display("test decode finished");
        for (int s = 0; s < 8; s++) begin
            for (int f = 0; f < 8; f++) begin
                cin_v = 1'($urandom);
                step(mk(KIND_EXTENDED, 4'h6, 2'h0, src_ctl_t'(3'(s)), alu_fn_t'(3'(f)), DST_NOP), $urandom);
            end
        end
        $display("test alu finished");
        for (int dd = 4; dd < 8; dd++) begin
            for (int ll = 0; ll < 4; ll++) begin
                link_v = shift_link_t'(2'(ll));
                li_v = 1'($urandom);
                step(mk(KIND_BASIC, 4'h2, 2'h0, SRC_D_Q, FN_ADD, dest_ctl_t'(3'(dd))), $urandom);
                step(mk(KIND_BASIC, 4'h2, 2'h0, SRC_Z_A, FN_OR, DST_NOP), 32'h0);
            end
        end
        $display("test shift finished");
        {cin_v, li_v} = 2'b00;
        link_v = LINK_ZERO;
        v = $urandom;
        step(mk(KIND_BASIC, 4'h0, 2'h0, SRC_D_Z, FN_ADD, DST_NOP), v);
        rdchk(OFS_RESULT, v);
        rdchk(OFS_STATUS, {28'h0, 2'b00, v[31], v == 32'h0});
        rdchk(OFS_Q, qv);
        bus(1'b1, OFS_CTRL, 32'h1, 4'h0);
        bus(1'b1, 4'h2, 32'hffffffff, 4'hf);
        rdchk(OFS_CTRL, 32'h0);
        rdchk(4'h2, 32'h0);
        bus(1'b1, OFS_CTRL, 32'h1, 4'h1);
        rdchk(OFS_CTRL, 32'h1);
        hold_v = 1'b1;
        step(mk(KIND_BASIC, 4'h0, 2'h0, SRC_D_Z, FN_ADD, DST_WRITE_B_F), $urandom);
        step(mk(KIND_BASIC, 4'h0, 2'h0, SRC_D_Z, FN_ADD, DST_LOAD_Q), $urandom);
        step(mk(KIND_BASIC, 4'h0, 2'h0, SRC_Z_A, FN_ADD, DST_NOP), 32'h0);
        bus(1'b1, OFS_CTRL, 32'h0, 4'h1);
        hold_v = 1'b0;
        step(mk(KIND_BASIC, 4'h0, 2'h0, SRC_A_Q, FN_ADD, DST_NOP), 32'h0);
        $display("test hold finished");
        for (int i = 0; i < 300; i++) begin
            cin_v = 1'($urandom);
            li_v = 1'($urandom);
            link_v = shift_link_t'(2'($urandom));
            step(mk(uinst_kind_t'(3'($urandom_range(0, 5))), 4'($urandom), 2'($urandom), src_ctl_t'(3'($urandom)),
                alu_fn_t'(3'($urandom)), dest_ctl_t'(3'($urandom))), $urandom);
        end
        step(mk(KIND_BASIC, 4'h0, 2'h0, SRC_A_Q, FN_ADD, DST_NOP), 32'h0);
        repeat (3) @(posedge clk_sys);
        $display("test random finished");
        complete_run();
    end
endmodule
`default_nettype wire
